// >>> hw/cswt_pkg.sv
// package: constants, types and decoders of the cyclic sense and wake timers
package cswt_pkg;
   localparam int CLK_KHZ      = 10000;
   localparam int BASE_TIME_US = 100;
   localparam int BASE_CYC     = BASE_TIME_US * CLK_KHZ / 1000;
   localparam int FILT_TIME_US = 16;
   localparam int FILT_CYC     = (FILT_TIME_US * CLK_KHZ + 999) / 1000;
   localparam logic [7:0] FILT_LAST = 8'(FILT_CYC - 1);
   localparam int N_HS  = 4;
   localparam int N_WK  = 3;
   localparam int N_TMR = 2;

   localparam logic [2:0] PER_10MS  = 3'h0;
   localparam logic [2:0] PER_20MS  = 3'h1;
   localparam logic [2:0] PER_50MS  = 3'h2;
   localparam logic [2:0] PER_100MS = 3'h3;
   localparam logic [2:0] PER_200MS = 3'h4;
   localparam logic [2:0] PER_1S    = 3'h5;
   localparam logic [2:0] PER_2S    = 3'h6;
   localparam int P10_US  = 10000;
   localparam int P20_US  = 20000;
   localparam int P50_US  = 50000;
   localparam int P100_US = 100000;
   localparam int P200_US = 200000;
   localparam int P1S_US  = 1000000;
   localparam int P2S_US  = 2000000;

   localparam logic [2:0] ON_OFF_LOW  = 3'h0;
   localparam logic [2:0] ON_100US    = 3'h1;
   localparam logic [2:0] ON_300US    = 3'h2;
   localparam logic [2:0] ON_1MS      = 3'h3;
   localparam logic [2:0] ON_10MS     = 3'h4;
   localparam logic [2:0] ON_20MS     = 3'h5;
   localparam logic [2:0] ON_OFF_HIGH = 3'h6;
   localparam int O100_US = 100;
   localparam int O300_US = 300;
   localparam int O1M_US  = 1000;
   localparam int O10M_US = 10000;
   localparam int O20M_US = 20000;

   localparam logic [1:0] MAP_NONE = 2'h0;
   localparam logic [1:0] MAP_T1   = 2'h1;
   localparam logic [1:0] MAP_T2   = 2'h2;

   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'b00,
      MODE_STOP     = 2'b01,
      MODE_SLEEP    = 2'b10,
      MODE_FAILSAFE = 2'b11
   } cswt_mode_e;

   typedef struct packed {
      logic [2:0] period;
      logic [2:0] ontime;
   } cswt_tmr_cfg_s;

   typedef struct packed {
      logic ovc;
      logic ovt;
      logic uv;
      logic ov;
   } cswt_hs_flt_s;

   function automatic logic [14:0] per_ticks(input logic [2:0] c);
      case (c)
         PER_10MS:  per_ticks = 15'(P10_US / BASE_TIME_US);
         PER_20MS:  per_ticks = 15'(P20_US / BASE_TIME_US);
         PER_50MS:  per_ticks = 15'(P50_US / BASE_TIME_US);
         PER_100MS: per_ticks = 15'(P100_US / BASE_TIME_US);
         PER_200MS: per_ticks = 15'(P200_US / BASE_TIME_US);
         PER_1S:    per_ticks = 15'(P1S_US / BASE_TIME_US);
         default:   per_ticks = 15'(P2S_US / BASE_TIME_US);
      endcase
   endfunction

   function automatic logic [14:0] on_ticks(input logic [2:0] c);
      case (c)
         ON_100US: on_ticks = 15'(O100_US / BASE_TIME_US);
         ON_300US: on_ticks = 15'(O300_US / BASE_TIME_US);
         ON_1MS:   on_ticks = 15'(O1M_US / BASE_TIME_US);
         ON_10MS:  on_ticks = 15'(O10M_US / BASE_TIME_US);
         ON_20MS:  on_ticks = 15'(O20M_US / BASE_TIME_US);
         default:  on_ticks = 15'h0000;
      endcase
   endfunction

   function automatic logic on_used(input logic [2:0] c);
      on_used = (on_ticks(c) != 15'h0000);
   endfunction

   // picks the timer signal that a map code selects
   function automatic logic pick(input logic [1:0] m, input logic [1:0] v);
      case (m)
         MAP_T1:  pick = v[0];
         MAP_T2:  pick = v[1];
         default: pick = 1'b0;
      endcase
   endfunction
endpackage

// >>> hw/cswt_timer.sv
// one periodic timer: period counter with on-time window
`timescale 1ns/10ps
`default_nettype none
module cswt_timer #(
   parameter int TICK_CYC = cswt_pkg::BASE_CYC
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire logic                    start,
   input  wire cswt_pkg::cswt_tmr_cfg_s cfg,
   output logic                         on_lvl,
   output logic                         on_start,
   output logic                         on_end,
   output logic                         first
);
   import cswt_pkg::*;
   localparam logic [15:0] PRE_LAST = 16'(TICK_CYC - 1);
   logic [15:0] pre_r, pre_nxt;
   logic [14:0] cnt_r, cnt_nxt, cnt_inc, per_t, on_t;
   logic        run_r, run_nxt, on_r, on_nxt, sp_r, sp_nxt;
   logic        ep_r, ep_nxt, fst_r, fst_nxt, tick, last;

   always_comb begin
      per_t   = per_ticks(cfg.period);
      on_t    = on_ticks(cfg.ontime);
      tick    = run_r && (pre_r == PRE_LAST);
      cnt_inc = 15'(cnt_r + 15'h0001);
      last    = (cnt_inc >= per_t);
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      on_nxt  = on_r;
      sp_nxt  = 1'b0;
      ep_nxt  = 1'b0;
      fst_nxt = sp_r ? 1'b0 : fst_r;
      if (start) begin
         pre_nxt = 16'h0000;
         cnt_nxt = 15'h0000;
         run_nxt = 1'b1;
         on_nxt  = on_used(cfg.ontime);
         sp_nxt  = 1'b1;
         fst_nxt = 1'b1;
      end else if (run_r) begin
         pre_nxt = tick ? 16'h0000 : 16'(pre_r + 16'h0001);
         if (tick) begin
            cnt_nxt = last ? 15'h0000 : cnt_inc;
            sp_nxt  = last;
            ep_nxt  = on_r && ((cnt_inc == on_t) || last);
            if (last) begin
               on_nxt = on_used(cfg.ontime);
            end else if (cnt_inc == on_t) begin
               on_nxt = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 16'h0000;
         cnt_r <= 15'h0000;
         run_r <= 1'b0;
         on_r  <= 1'b0;
         sp_r  <= 1'b0;
         ep_r  <= 1'b0;
         fst_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         on_r  <= on_nxt;
         sp_r  <= sp_nxt;
         ep_r  <= ep_nxt;
         fst_r <= fst_nxt;
      end
   end

   assign on_lvl   = on_r;
   assign on_start = sp_r;
   assign on_end   = ep_r;
   assign first    = fst_r;
endmodule
`default_nettype wire

// >>> hw/cswt_top.sv
// top: two cyclic sense / cyclic wake timers with driver, wake and fault logic
`timescale 1ns/10ps
`default_nettype none
module cswt_top #(
   parameter int TICK_CYC = cswt_pkg::BASE_CYC
) (
   input  wire logic                                    clk_sys,
   input  wire logic                                    rst_n,
   input  wire cswt_pkg::cswt_mode_e                    mode,
   input  wire cswt_pkg::cswt_tmr_cfg_s                 first_timer_control,
   input  wire logic                                    first_timer_wr,
   input  wire cswt_pkg::cswt_tmr_cfg_s                 second_timer_control,
   input  wire logic                                    second_timer_wr,
   input  wire logic [cswt_pkg::N_HS-1:0][1:0]          highside_map_control_a,
   input  wire logic [cswt_pkg::N_WK-1:0][1:0]          wake_sense_map,
   input  wire logic [cswt_pkg::N_TMR-1:0]              wake_source_control,
   input  wire logic                                    uvov_shutdown_en,
   input  wire cswt_pkg::cswt_hs_flt_s [cswt_pkg::N_HS-1:0] hs_fault,
   input  wire logic [cswt_pkg::N_HS-1:0]               hs_fault_clr,
   input  wire logic [cswt_pkg::N_WK-1:0]               wake_input_pin,
   input  wire logic [cswt_pkg::N_WK-1:0]               wake_status_a_clr,
   input  wire logic [cswt_pkg::N_TMR-1:0]              wake_status_b_clr,
   input  wire logic                                    spi_fail_clr,
   input  wire logic                                    sleep_req,
   output logic [cswt_pkg::N_HS-1:0]                    highside_driver,
   output logic [cswt_pkg::N_HS-1:0]                    hs_fault_off,
   output logic [cswt_pkg::N_WK-1:0]                    wake_status_a,
   output logic [cswt_pkg::N_TMR-1:0]                   wake_status_b,
   output logic [cswt_pkg::N_WK-1:0]                    wake_level_status,
   output logic                                         spi_fail,
   output logic                                         irq_n,
   output logic                                         main_regulator_wake
);
   import cswt_pkg::*;

   cswt_tmr_cfg_s [N_TMR-1:0] tcfg;
   logic [N_TMR-1:0] t_wr, t_on, t_start, t_end, t_first, t_hi, tw_evt, bad_wr;
   logic             fs, awake;

   assign tcfg = {second_timer_control, first_timer_control};
   assign t_wr = {second_timer_wr, first_timer_wr};
   assign fs    = (mode == MODE_FAILSAFE);
   assign awake = (mode == MODE_NORMAL) || (mode == MODE_STOP);

   for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
      cswt_timer #(
         .TICK_CYC (TICK_CYC)
      ) u_tmr (
         .clk_sys  (clk_sys),
         .rst_n    (rst_n),
         .start    (t_wr[g]),
         .cfg      (tcfg[g]),
         .on_lvl   (t_on[g]),
         .on_start (t_start[g]),
         .on_end   (t_end[g]),
         .first    (t_first[g])
      );
   end

   // wake input synchronisers and sampling channels
   logic [N_WK-1:0]      s1_r, s2_r, s3_r, lvl_r, s1_nxt, s2_nxt, s3_nxt, lvl_nxt;
   logic [N_WK-1:0]      fact_r, fact_nxt, flvl_r, flvl_nxt, ref_r, ref_nxt;
   logic [N_WK-1:0]      refv_r, refv_nxt, lvst_r, lvst_nxt, flga_r, flga_nxt;
   logic [N_WK-1:0]      cyc, done, wk_evt;
   logic [N_WK-1:0][7:0] fcnt_r, fcnt_nxt;

   always_comb begin
      s1_nxt = wake_input_pin;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      for (int i = 0; i < N_WK; i++) begin
         lvl_nxt[i]  = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
         cyc[i]      = (wake_sense_map[i] != MAP_NONE) && !fs;
         done[i]     = 1'b0;
         wk_evt[i]   = 1'b0;
         fact_nxt[i] = fact_r[i];
         fcnt_nxt[i] = fcnt_r[i];
         flvl_nxt[i] = flvl_r[i];
         ref_nxt[i]  = ref_r[i];
         refv_nxt[i] = refv_r[i];
         lvst_nxt[i] = lvst_r[i];
         if (!cyc[i]) begin
            fact_nxt[i] = 1'b0;
            refv_nxt[i] = 1'b0;
            ref_nxt[i]  = lvl_r[i];
            lvst_nxt[i] = lvl_r[i];
            wk_evt[i]   = fs && (wake_sense_map[i] != MAP_NONE) && (lvl_r[i] != ref_r[i]);
         end else if (pick(wake_sense_map[i], t_end)) begin
            fact_nxt[i] = 1'b1;
            fcnt_nxt[i] = 8'h00;
            flvl_nxt[i] = lvl_r[i];
         end else if (fact_r[i]) begin
            if (lvl_r[i] != flvl_r[i]) begin
               fact_nxt[i] = 1'b0;
            end else if (fcnt_r[i] == FILT_LAST) begin
               done[i]     = 1'b1;
               fact_nxt[i] = 1'b0;
               ref_nxt[i]  = flvl_r[i];
               refv_nxt[i] = 1'b1;
               lvst_nxt[i] = flvl_r[i];
               wk_evt[i]   = refv_r[i] && (flvl_r[i] != ref_r[i]);
            end else begin
               fcnt_nxt[i] = 8'(fcnt_r[i] + 8'h01);
            end
         end
         flga_nxt[i] = (flga_r[i] && !wake_status_a_clr[i]) || wk_evt[i];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         lvl_r  <= '0;
         fact_r <= '0;
         fcnt_r <= '0;
         flvl_r <= '0;
         ref_r  <= '0;
         refv_r <= '0;
         lvst_r <= '0;
         flga_r <= '0;
      end else begin
         s1_r   <= s1_nxt;
         s2_r   <= s2_nxt;
         s3_r   <= s3_nxt;
         lvl_r  <= lvl_nxt;
         fact_r <= fact_nxt;
         fcnt_r <= fcnt_nxt;
         flvl_r <= flvl_nxt;
         ref_r  <= ref_nxt;
         refv_r <= refv_nxt;
         lvst_r <= lvst_nxt;
         flga_r <= flga_nxt;
      end
   end

   // drivers, faults, timer flags, interrupt and restart request
   logic [N_HS-1:0]  flt_r, flt_nxt, drv_r, drv_nxt, flt_evt, src;
   logic [N_TMR-1:0] flgb_r, flgb_nxt;
   logic             sf_r, sf_nxt, irq_n_r, irq_n_nxt, rw_r, rw_nxt;

   always_comb begin
      for (int t = 0; t < N_TMR; t++) begin
         t_hi[t]   = (tcfg[t].ontime == ON_OFF_HIGH);
         tw_evt[t] = wake_source_control[t] && t_start[t] && !t_first[t] && awake;
         bad_wr[t] = t_wr[t] && on_used(tcfg[t].ontime)
                     && (on_ticks(tcfg[t].ontime) > per_ticks(tcfg[t].period));
      end
      flgb_nxt  = (flgb_r & ~wake_status_b_clr) | tw_evt;
      sf_nxt    = (sf_r && !spi_fail_clr) || (|bad_wr);
      irq_n_nxt = !(awake && ((|wk_evt) || (|tw_evt)));
      rw_nxt    = (!awake && (|wk_evt)) || (sleep_req && ((|flga_r) || (|flgb_r)));
      for (int h = 0; h < N_HS; h++) begin
         flt_evt[h] = !fs && (hs_fault[h].ovc || hs_fault[h].ovt
                      || (uvov_shutdown_en && (hs_fault[h].uv || hs_fault[h].ov)));
         flt_nxt[h] = (flt_r[h] && !hs_fault_clr[h]) || flt_evt[h];
         src[h]     = pick(highside_map_control_a[h], t_on | t_hi);
         drv_nxt[h] = !fs && !flt_r[h] && !flt_evt[h] && src[h];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flt_r   <= '0;
         drv_r   <= '0;
         flgb_r  <= '0;
         sf_r    <= 1'b0;
         irq_n_r <= 1'b1;
         rw_r    <= 1'b0;
      end else begin
         flt_r   <= flt_nxt;
         drv_r   <= drv_nxt;
         flgb_r  <= flgb_nxt;
         sf_r    <= sf_nxt;
         irq_n_r <= irq_n_nxt;
         rw_r    <= rw_nxt;
      end
   end

   assign highside_driver     = drv_r;
   assign hs_fault_off        = flt_r;
   assign wake_status_a       = flga_r;
   assign wake_status_b       = flgb_r;
   assign wake_level_status   = lvst_r;
   assign spi_fail            = sf_r;
   assign irq_n               = irq_n_r;
   assign main_regulator_wake = rw_r;

   property p_start;
      @(posedge clk_sys) disable iff (!rst_n) first_timer_wr |=> t_start[0] && t_first[0];
   endproperty
   a_start: assert property (p_start) else $error("timer did not start on write");

   property p_sfail;
      @(posedge clk_sys) disable iff (!rst_n) bad_wr[0] |=> spi_fail;
   endproperty
   a_sfail: assert property (p_sfail) else $error("failure flag not set");

   property p_offhi;
      @(posedge clk_sys) disable iff (!rst_n)
         (!fs && highside_map_control_a[0] == MAP_T1 && t_hi[0] && !flt_r[0] && !flt_evt[0])
         |=> highside_driver[0];
   endproperty
   a_offhi: assert property (p_offhi) else $error("off-high level not driven");

   property p_ref;
      @(posedge clk_sys) disable iff (!rst_n) (done[0] && !refv_r[0]) |-> !wk_evt[0];
   endproperty
   a_ref: assert property (p_ref) else $error("first sample caused a wake");

   property p_filt;
      @(posedge clk_sys) disable iff (!rst_n) done[0] |-> $past(fact_r[0], 159);
   endproperty
   a_filt: assert property (p_filt) else $error("sample taken before filter end");

   property p_flag;
      @(posedge clk_sys) disable iff (!rst_n) wk_evt[0] |=> wake_status_a[0];
   endproperty
   a_flag: assert property (p_flag) else $error("wake flag not set");

   property p_lvl;
      @(posedge clk_sys) disable iff (!rst_n)
         (cyc[0] && !done[0] && awake) |=> $stable(wake_level_status[0]);
   endproperty
   a_lvl: assert property (p_lvl) else $error("level status moved between samples");

   property p_irq;
      @(posedge clk_sys) disable iff (!rst_n)
         (wk_evt[0] && mode == MODE_STOP) |=> !irq_n ##1 irq_n || !irq_n;
   endproperty
   a_irq: assert property (p_irq) else $error("no interrupt in stop mode");

   property p_fs;
      @(posedge clk_sys) disable iff (!rst_n) fs [*2] |-> highside_driver == '0;
   endproperty
   a_fs: assert property (p_fs) else $error("driver on in fail-safe");

   property p_flt;
      @(posedge clk_sys) disable iff (!rst_n)
         flt_evt[0] |=> !highside_driver[0] && hs_fault_off[0];
   endproperty
   a_flt: assert property (p_flt) else $error("driver not shut off on fault");

   property p_sleep;
      @(posedge clk_sys) disable iff (!rst_n)
         (sleep_req && (|wake_status_a)) |=> main_regulator_wake;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not refused with pending flag");

   property p_cwake;
      @(posedge clk_sys) disable iff (!rst_n)
         (t_start[0] && t_first[0] && wk_evt == '0 && !tw_evt[1]) |=> irq_n;
   endproperty
   a_cwake: assert property (p_cwake) else $error("interrupt on first on-time");

   property p_drvon;
      @(posedge clk_sys) disable iff (!rst_n)
         (!fs && highside_map_control_a[0] == MAP_T1 && t_on[0] && !flt_r[0] && !flt_evt[0])
         |=> highside_driver[0];
   endproperty
   a_drvon: assert property (p_drvon) else $error("driver off during on-time");

   property p_wsb;
      @(posedge clk_sys) disable iff (!rst_n) tw_evt[0] |=> wake_status_b[0];
   endproperty
   a_wsb: assert property (p_wsb) else $error("cyclic wake flag not set");

   property p_cwirq;
      @(posedge clk_sys) disable iff (!rst_n) tw_evt[0] |=> !irq_n;
   endproperty
   a_cwirq: assert property (p_cwirq) else $error("no cyclic wake interrupt");

   property p_slpwk;
      @(posedge clk_sys) disable iff (!rst_n)
         (wk_evt[0] && mode == MODE_SLEEP) |=> main_regulator_wake;
   endproperty
   a_slpwk: assert property (p_slpwk) else $error("no regulator wake in sleep");

   property p_sfail2;
      @(posedge clk_sys) disable iff (!rst_n) bad_wr[1] |=> spi_fail;
   endproperty
   a_sfail2: assert property (p_sfail2) else $error("failure flag not set for timer 2");

   property p_chg;
      @(posedge clk_sys) disable iff (!rst_n)
         (cyc[0] && done[0] && refv_r[0] && (flvl_r[0] != ref_r[0])) |-> wk_evt[0];
   endproperty
   a_chg: assert property (p_chg) else $error("level change gave no wake");

   property p_flghold;
      @(posedge clk_sys) disable iff (!rst_n)
         (wake_status_a[0] && !wake_status_a_clr[0]) |=> wake_status_a[0];
   endproperty
   a_flghold: assert property (p_flghold) else $error("wake flag lost without clear");
endmodule
`default_nettype wire

// >>> verif/cswt_mcu_model.sv
// controller model: drives timer, driver mapping and wake-source setup
`timescale 1ns/10ps
`default_nettype none
module cswt_mcu_model (
   input  wire logic                           clk_sys,
   output cswt_pkg::cswt_tmr_cfg_s             t1_cfg,
   output logic                                t1_wr,
   output cswt_pkg::cswt_tmr_cfg_s             t2_cfg,
   output logic                                t2_wr,
   output logic [cswt_pkg::N_HS-1:0][1:0]      hs_map,
   output logic [cswt_pkg::N_WK-1:0][1:0]      wk_map,
   output logic [cswt_pkg::N_TMR-1:0]          wk_src
);
   import cswt_pkg::*;
   initial begin
      t1_cfg = '0;
      t1_wr = 1'b0;
      t2_cfg = '0;
      t2_wr = 1'b0;
      hs_map = '0;
      wk_map = '0;
      wk_src = '0;
   end
   // source off, map, wake map and source, then timer last
   task automatic sense(input logic [1:0] m, input logic [1:0] w, input logic [2:0] p,
                        input logic [2:0] o, input logic src);
      @(posedge clk_sys) wk_src <= '0;
      @(posedge clk_sys) hs_map[0] <= m;
      @(posedge clk_sys) begin
         wk_map[0] <= w;
         wk_src[0] <= src;
      end
      @(posedge clk_sys) begin
         t1_cfg <= '{period: p, ontime: o};
         t1_wr <= 1'b1;
      end
      @(posedge clk_sys) t1_wr <= 1'b0;
   endtask
   // second timer onto the second driver
   task automatic second(input logic [2:0] o);
      @(posedge clk_sys) hs_map[1] <= MAP_T2;
      @(posedge clk_sys) begin
         t2_cfg <= '{period: PER_10MS, ontime: o};
         t2_wr <= 1'b1;
      end
      @(posedge clk_sys) t2_wr <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_cswt_top.sv
// testbench: timers driven through a controller model and checked against expected values
`timescale 1ns/10ps
`default_nettype none
module tb_cswt_top;
   import cswt_pkg::*;
   localparam int TICK = 4;
   logic                    clk_sys = 1'b0;
   logic                    rst_n = 1'b0;
   cswt_mode_e              mode = MODE_NORMAL;
   cswt_tmr_cfg_s           t1_cfg, t2_cfg;
   logic                    t1_wr, t2_wr, spi_fail, irq_n, mrw, cur;
   logic [N_HS-1:0][1:0]    hs_map;
   logic [N_WK-1:0][1:0]    wk_map;
   logic [N_TMR-1:0]        wk_src, wsb;
   logic                    uvov_en = 1'b0;
   cswt_hs_flt_s [N_HS-1:0] hs_fault = '0;
   logic [N_HS-1:0]         hs_clr = '0;
   logic [N_WK-1:0]         pin = '0;
   logic [N_WK-1:0]         wsa_clr = '0;
   logic [N_TMR-1:0]        wsb_clr = '0;
   logic                    spi_clr = 1'b0;
   logic                    sleep_req = 1'b0;
   logic [N_HS-1:0]         drv, hs_off;
   logic [N_WK-1:0]         wsa, wls;
   logic                    flag = 1'b0;
   logic [16:0]             rnd = 17'h176c1;
   int num_errors = 0;
   int n_checks = 0;
   int n_irq = 0;
   int n_mrw = 0;
   int n_hs0 = 0;
   int exp_irq = 0;
   int exp_mrw = 0;
   int on_us[8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
   int per_ms[7] = '{10, 20, 50, 100, 200, 1000, 2000};
   bit smp[$];

   cswt_mcu_model cswt_mcu_model_i (.clk_sys(clk_sys), .t1_cfg(t1_cfg), .t1_wr(t1_wr),
      .t2_cfg(t2_cfg), .t2_wr(t2_wr), .hs_map(hs_map), .wk_map(wk_map), .wk_src(wk_src));
   cswt_top #(.TICK_CYC(TICK)) cswt_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .mode(mode),
      .first_timer_control(t1_cfg), .first_timer_wr(t1_wr), .second_timer_control(t2_cfg),
      .second_timer_wr(t2_wr), .highside_map_control_a(hs_map), .wake_sense_map(wk_map),
      .wake_source_control(wk_src), .uvov_shutdown_en(uvov_en), .hs_fault(hs_fault),
      .hs_fault_clr(hs_clr), .wake_input_pin(pin), .wake_status_a_clr(wsa_clr),
      .wake_status_b_clr(wsb_clr), .spi_fail_clr(spi_clr), .sleep_req(sleep_req),
      .highside_driver(drv), .hs_fault_off(hs_off), .wake_status_a(wsa),
      .wake_status_b(wsb), .wake_level_status(wls), .spi_fail(spi_fail), .irq_n(irq_n),
      .main_regulator_wake(mrw));

   always #50 clk_sys = ~clk_sys;

   // event counters see the value settled before each edge
   always @(posedge clk_sys) begin
      n_irq = n_irq + int'(!irq_n);
      n_mrw = n_mrw + int'(mrw);
      n_hs0 = n_hs0 + int'(drv[0]);
   end

   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      chk(16'(got), 16'(exp));
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk_sys);
      num_errors++;
      give_verdict();
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      cyc(2);
      for (int p = 0; p < 7; p++) begin
         for (int o = 0; o < 8; o++) begin
            @(posedge clk_sys) spi_clr <= 1'b1;
            @(posedge clk_sys) spi_clr <= 1'b0;
            cswt_mcu_model_i.sense(MAP_NONE, MAP_NONE, 3'(p), 3'(o), 1'b0);
            cyc(2);
            chk(16'(spi_fail), 16'(on_us[o] > per_ms[p] * 1000));
         end
      end
      for (int o = 1; o < 6; o++) begin
         cswt_mcu_model_i.sense(MAP_T1, MAP_NONE, PER_50MS, 3'(o), 1'b0);
         #1;
         n_hs0 = 0;
         cyc(1500);
         chk_n(n_hs0, on_us[o] / 100 * TICK);
      end
      cswt_mcu_model_i.sense(MAP_T1, MAP_NONE, PER_10MS, ON_OFF_HIGH, 1'b0);
      cswt_mcu_model_i.second(ON_OFF_HIGH);
      cyc(3);
      chk(16'(drv), 16'h3);
      cswt_mcu_model_i.sense(MAP_T1, MAP_NONE, PER_10MS, ON_OFF_LOW, 1'b0);
      cswt_mcu_model_i.second(ON_OFF_LOW);
      cyc(3);
      chk(16'(drv), 16'h0);
      // cyclic wake with a driver fault in the first window
      cswt_mcu_model_i.sense(MAP_T1, MAP_NONE, PER_10MS, ON_1MS, 1'b1);
      #1;
      n_irq = 0;
      cyc(8);
      @(posedge clk_sys) hs_fault[0].ovc <= 1'b1;
      cyc(2);
      chk(16'({drv[0], hs_off[0]}), 16'h1);
      @(posedge clk_sys) hs_fault[0].ovc <= 1'b0;
      cyc(1196);
      chk_n(n_irq, 3);
      chk(16'(wsb), 16'h1);
      @(posedge clk_sys) begin
         hs_clr <= 4'h1;
         wsb_clr <= 2'h3;
         hs_fault[0].uv <= 1'b1;
      end
      @(posedge clk_sys) begin
         hs_clr <= 4'h0;
         wsb_clr <= 2'h0;
      end
      cyc(3);
      chk(16'({hs_off[0], wsb}), 16'h0);
      @(posedge clk_sys) uvov_en <= 1'b1;
      cyc(2);
      chk(16'(hs_off[0]), 16'h1);
      for (int m = 1; m < 3; m++) begin
         @(posedge clk_sys) mode <= cswt_mode_e'(m);
         cyc(2);
         n_irq = 0;
         cyc(800);
         chk_n(n_irq, (m == 1) ? 2 : 0);
      end
      @(posedge clk_sys) begin
         mode <= MODE_NORMAL;
         hs_fault[0].uv <= 1'b0;
         hs_clr <= 4'h1;
      end
      @(posedge clk_sys) hs_clr <= 4'h0;
      // short on-time for sensing
      cswt_mcu_model_i.sense(MAP_T1, MAP_T1, PER_10MS, ON_100US, 1'b0);
      #1;
      n_irq = 0;
      n_mrw = 0;
      for (int k = 0; k < 8; k++) begin
         cyc(199);
         cur = pin[0];
         if (smp.size() > 0 && smp[$] != cur) begin
            flag = 1'b1;
            if (mode == MODE_SLEEP) exp_mrw++;
            else exp_irq++;
         end
         smp.push_back(cur);
         if (mode != MODE_SLEEP) chk(16'(wls[0]), 16'(cur));
         chk(16'(wsa[0]), 16'(flag));
         chk_n(n_irq, exp_irq);
         chk_n(n_mrw, exp_mrw);
         rnd = lfsr(rnd);
         cyc(49);
         @(posedge clk_sys) begin
            pin[0] <= (k == 1) ? ~cur : ((k == 7) ? cur : rnd[0]);
            if (k == 4) mode <= MODE_SLEEP;
         end
         cyc(50);
         if (mode != MODE_SLEEP) chk(16'(wls[0]), 16'(cur));
         cyc(101);
      end
      @(posedge clk_sys) mode <= MODE_NORMAL;
      @(posedge clk_sys) sleep_req <= 1'b1;
      @(posedge clk_sys) sleep_req <= 1'b0;
      cyc(3);
      chk_n(n_mrw, exp_mrw + 1);
      @(posedge clk_sys) begin
         wsa_clr <= 3'h7;
         wsb_clr <= 2'h3;
      end
      @(posedge clk_sys) begin
         wsa_clr <= 3'h0;
         wsb_clr <= 2'h0;
      end
      @(posedge clk_sys) sleep_req <= 1'b1;
      @(posedge clk_sys) sleep_req <= 1'b0;
      cyc(3);
      chk_n(n_mrw, exp_mrw + 1);
      chk(16'({wsa, wsb}), 16'h0);
      @(posedge clk_sys) mode <= MODE_FAILSAFE;
      cyc(2);
      n_hs0 = 0;
      cyc(400);
      chk_n(n_hs0, 0);
      @(posedge clk_sys) pin[0] <= ~pin[0];
      cyc(200);
      chk_n(n_mrw, exp_mrw + 2);
      chk(16'(wsa[0]), 16'h1);
      give_verdict();
   end
endmodule
`default_nettype wire
